// ---- hdl/sat_pkg.sv ----
package sat_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] ADDR_RATED_VOLTAGE = 12'h000;
	localparam logic [11:0] ADDR_POLE_COUNT = 12'h004;
	localparam logic [11:0] ADDR_AUTOTUNE_SEL = 12'h008;
	localparam logic [11:0] ADDR_CONTROL = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h014;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
	localparam logic [11:0] ADDR_MOTOR_SET = 12'h01C;
	localparam logic [11:0] ADDR_VOLT_LIMIT = 12'h020;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_REVERSE_SEL_BIT = 1;
	localparam int CTL_SECOND_MOTOR_BIT = 2;
	localparam int CTL_WORD_ENABLE_BIT = 3;
	localparam int CTL_COPY_MODE_LSB = 4;
	localparam logic [7:0] AUTOTUNE_SEL_MAX = 8'h06;
	localparam logic [7:0] AUTOTUNE_GAINS_ONLY = 8'h06;
	localparam logic [7:0] AUTOTUNE_SHORT_LOW = 8'h01;
	localparam logic [7:0] POLE_CODE_MAX = 8'h3C;
	localparam logic [7:0] POLE_RESET = 8'h03;
	localparam logic [7:0] POLE_AUTO_POLES = 8'h06;
	localparam logic [2:0] COPY_AUTO = 3'h3;
	localparam logic [2:0] COPY_BOOT = 3'h4;
	localparam logic [15:0] VOLT_200_RATING = 16'h00E6;
	localparam logic [15:0] VOLT_400_EUR = 16'h0190;
	localparam logic [15:0] VOLT_400_USA = 16'h01E0;
	localparam logic [15:0] VOLT_600_RATING = 16'h023F;
	localparam logic [15:0] VOLT_690_RATING = 16'h02B2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int SHORT_TEST_MS = 2000;
	localparam int SHORT_TEST_CYCLES = (CLK_HZ / 1000) * SHORT_TEST_MS;
	localparam int ELEC_REVS = 2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {SAT_RATING_200, SAT_RATING_400, SAT_RATING_600, SAT_RATING_690} sat_rating_t;

	typedef struct packed {
		logic valid;
		logic second_set;
		logic card;
		logic [2:0] item;
		logic [15:0] value;
	} sat_store_t;

	localparam logic [2:0] ITEM_PHASE = 3'h1;
	localparam logic [2:0] ITEM_GAINS = 3'h2;

endpackage

// ---- hdl/sat_sequencer.sv ----
`timescale 1ns/1ps

module sat_sequencer #(
	parameter int SHORT_CYCLES = sat_pkg::SHORT_TEST_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [1:0] rating_i,
	input wire logic usa_i,
	input wire logic enable_pin_i,
	input wire logic run_fwd_i,
	input wire logic run_rev_i,
	input wire logic trip_i,
	input wire logic motor_stopped_i,
	input wire logic rev_done_i,
	input wire logic [15:0] phase_meas_i,
	input wire logic [15:0] stator_res_i,
	input wire logic [15:0] trans_ind_i,
	input wire logic [15:0] headroom_i,
	output logic drive_en_o,
	output logic inhibit_o,
	output logic stop_state_o,
	output logic rotate_o,
	output logic reverse_o,
	output logic [1:0] revs_target_o,
	output logic busy_o,
	output logic gain_recalc_o,
	output logic [7:0] poles_o,
	output logic [15:0] volt_limit_o,
	output sat_pkg::sat_store_t store_o,
	output logic irq_o
);

	typedef enum {S_IDLE, S_ROTATE, S_SETTLE, S_GAINS, S_DONE} sat_state_t;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic rev_seen;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			rev_seen <= 1'b0;
		end else begin
			sync1 <= {enable_pin_i, run_fwd_i, run_rev_i, trip_i, motor_stopped_i, rev_done_i};
			sync2 <= sync1;
			rev_seen <= sync2[0];
		end
	end
	wire en_pin = sync2[5];
	wire run_f = sync2[4];
	wire run_r = sync2[3];
	wire trip = sync2[2];
	wire stopped = sync2[1];
	wire rev_done = sync2[0];
	// Count pulses, not cycles: the encoder holds its rev pulse for several clocks
	wire rev_rise = rev_done && !rev_seen;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] rated_voltage;
	logic [7:0] pole_code;
	logic [7:0] sel;
	logic [6:0] ctrl;
	logic [3:0] irq_st;
	logic [3:0] irq_mask;
	logic rating_loaded;
	sat_state_t state;
	logic [31:0] cnt;
	logic [1:0] revs;
	logic run_dir_rev;
	logic second_latched;
	logic was_disabled;
	logic need_release;
	logic ev_start;
	logic ev_done;
	logic ev_trip;
	logic ev_store;

	function automatic logic [15:0] rating_default(input logic [1:0] r, input logic usa);
		case (r)
			2'h0: rating_default = sat_pkg::VOLT_200_RATING;
			2'h1: rating_default = usa ? sat_pkg::VOLT_400_USA : sat_pkg::VOLT_400_EUR;
			2'h2: rating_default = sat_pkg::VOLT_600_RATING;
			default: rating_default = sat_pkg::VOLT_690_RATING;
		endcase
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		hit = (a == b);
	endfunction

	// Writes land only on the edge where the master sees pready, never twice
	wire wr = psel_i && penable_i && pwrite_i && pready_o;
	wire enabled = ctrl[sat_pkg::CTL_ENABLE_BIT] && ctrl[sat_pkg::CTL_WORD_ENABLE_BIT] && en_pin;
	wire run_any = run_f || run_r;
	wire [2:0] copy_mode = ctrl[sat_pkg::CTL_COPY_MODE_LSB +: 3];
	wire gains_ok = (stator_res_i != 16'h0000) && (trans_ind_i != 16'h0000);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rated_voltage <= sat_pkg::VOLT_200_RATING;
			rating_loaded <= 1'b0;
			pole_code <= sat_pkg::POLE_RESET;
			sel <= 8'h00;
			ctrl <= 7'h00;
			irq_mask <= 4'h0;
		end else begin
			// Rating straps are static; read once on the first edge out of reset
			if (!rating_loaded) begin
				rating_loaded <= 1'b1;
				rated_voltage <= rating_default(rating_i, usa_i);
			end else if (wr && hit(paddr_i, sat_pkg::ADDR_RATED_VOLTAGE)) begin
				rated_voltage <= pwdata_i[15:0];
			end
			if (wr && hit(paddr_i, sat_pkg::ADDR_POLE_COUNT) && pwdata_i[7:0] <= sat_pkg::POLE_CODE_MAX) begin
				pole_code <= pwdata_i[7:0];
			end
			if (wr && hit(paddr_i, sat_pkg::ADDR_AUTOTUNE_SEL) && pwdata_i[7:0] <= sat_pkg::AUTOTUNE_SEL_MAX) begin
				sel <= pwdata_i[7:0];
			end else if (state == S_DONE || (sel == sat_pkg::AUTOTUNE_GAINS_ONLY && state == S_GAINS)) begin
				sel <= 8'h00;
			end
			if (wr && hit(paddr_i, sat_pkg::ADDR_CONTROL)) begin
				ctrl <= pwdata_i[6:0];
			end
			if (wr && hit(paddr_i, sat_pkg::ADDR_IRQ_MASK)) begin
				irq_mask <= pwdata_i[3:0];
			end
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Remember disabled-before-start so a test never launches out of a running drive
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			was_disabled <= 1'b0;
			need_release <= 1'b0;
		end else begin
			if (!enabled) begin
				was_disabled <= 1'b1;
			end else if (state != S_IDLE || sel == 8'h00) begin
				// Stopped or running without a selector: a later selector write must not start
				was_disabled <= 1'b0;
			end
			if (state == S_DONE) begin
				need_release <= 1'b1;
			end else if (!enabled) begin
				need_release <= 1'b0;
			end
		end
	end

	wire start_ok = sel != 8'h00 && sel != sat_pkg::AUTOTUNE_GAINS_ONLY && enabled && run_any
		&& was_disabled && !need_release && state == S_IDLE;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= S_IDLE;
			cnt <= 32'h0;
			revs <= 2'h0;
			run_dir_rev <= 1'b0;
			second_latched <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					cnt <= 32'h0;
					revs <= 2'h0;
					if (sel == sat_pkg::AUTOTUNE_GAINS_ONLY) begin
						state <= S_GAINS;
					end else if (start_ok) begin
						run_dir_rev <= ctrl[sat_pkg::CTL_REVERSE_SEL_BIT] || run_r;
						second_latched <= ctrl[sat_pkg::CTL_SECOND_MOTOR_BIT];
						state <= (sel == sat_pkg::AUTOTUNE_SHORT_LOW) ? S_ROTATE : S_GAINS;
					end
				end
				S_ROTATE: begin
					cnt <= cnt + 32'h1;
					if (trip) begin
						state <= S_IDLE;
					end else begin
						if (rev_rise) begin
							revs <= revs + 2'h1;
						end
						if (revs == 2'(sat_pkg::ELEC_REVS)) begin
							state <= S_SETTLE;
						end
					end
				end
				S_SETTLE: begin
					// Counter runs from the start, so the limit bounds the whole test, not the settle
					cnt <= cnt + 32'h1;
					if (trip) begin
						state <= S_IDLE;
					end else if (stopped && cnt >= 32'(SHORT_CYCLES)) begin
						state <= S_DONE;
					end
				end
				S_GAINS: begin
					state <= (sel == sat_pkg::AUTOTUNE_GAINS_ONLY) ? S_IDLE : S_DONE;
				end
				S_DONE: begin
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs and stores
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drive_en_o <= 1'b0;
			inhibit_o <= 1'b1;
			stop_state_o <= 1'b0;
			rotate_o <= 1'b0;
			reverse_o <= 1'b0;
			revs_target_o <= 2'h0;
			busy_o <= 1'b0;
			gain_recalc_o <= 1'b0;
			poles_o <= sat_pkg::POLE_AUTO_POLES;
			volt_limit_o <= 16'h0000;
			store_o <= '0;
		end else begin
			drive_en_o <= enabled && !need_release && state != S_DONE;
			inhibit_o <= !enabled || need_release || state == S_DONE;
			stop_state_o <= enabled && !run_any && sel == 8'h00;
			rotate_o <= state == S_ROTATE;
			reverse_o <= run_dir_rev;
			revs_target_o <= 2'(sat_pkg::ELEC_REVS);
			busy_o <= state == S_ROTATE || state == S_SETTLE;
			gain_recalc_o <= state == S_GAINS && gains_ok;
			poles_o <= (pole_code == 8'h00) ? sat_pkg::POLE_AUTO_POLES : 8'(pole_code * 2);
			volt_limit_o <= (rated_voltage < headroom_i) ? rated_voltage : headroom_i;
			store_o.valid <= (state == S_SETTLE && !trip && stopped && cnt >= 32'(SHORT_CYCLES))
				|| (state == S_GAINS && gains_ok && sel != sat_pkg::AUTOTUNE_GAINS_ONLY);
			store_o.second_set <= second_latched;
			store_o.card <= copy_mode == sat_pkg::COPY_AUTO || copy_mode == sat_pkg::COPY_BOOT;
			store_o.item <= (state == S_GAINS) ? sat_pkg::ITEM_GAINS : sat_pkg::ITEM_PHASE;
			store_o.value <= phase_meas_i;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_comb begin
		ev_start = state == S_IDLE && start_ok;
		ev_done = state == S_DONE;
		ev_trip = (state == S_ROTATE || state == S_SETTLE) && trip;
		ev_store = store_o.valid;
	end

	// Set beats write-one-clear so an event in the clearing cycle survives
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_st <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			irq_st <= (irq_st & ~((wr && hit(paddr_i, sat_pkg::ADDR_IRQ_STATUS)) ? pwdata_i[3:0] : 4'h0))
				| {ev_store, ev_trip, ev_done, ev_start};
			irq_o <= |(irq_st & irq_mask);
		end
	end

	// ----------------------------------------
	// APB read path, one wait state
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && penable_i && !pready_o;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
			if (psel_i && penable_i && !pready_o) begin
				case (paddr_i)
					sat_pkg::ADDR_RATED_VOLTAGE: prdata_o <= {16'h0000, rated_voltage};
					sat_pkg::ADDR_POLE_COUNT: prdata_o <= {24'h000000, pole_code};
					sat_pkg::ADDR_AUTOTUNE_SEL: prdata_o <= {24'h000000, sel};
					sat_pkg::ADDR_CONTROL: prdata_o <= {25'h0000000, ctrl};
					sat_pkg::ADDR_STATUS: prdata_o <= {28'h0000000, need_release, busy_o, inhibit_o, drive_en_o};
					sat_pkg::ADDR_IRQ_STATUS: prdata_o <= {28'h0000000, irq_st};
					sat_pkg::ADDR_IRQ_MASK: prdata_o <= {28'h0000000, irq_mask};
					sat_pkg::ADDR_MOTOR_SET: prdata_o <= {31'h00000000, second_latched};
					sat_pkg::ADDR_VOLT_LIMIT: prdata_o <= {16'h0000, volt_limit_o};
					default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_busy_trip_end: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		ev_trip |=> state == S_IDLE ##1 !busy_o) else $error("trip did not end test");
	chk_done_disable: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		state == S_DONE |=> !drive_en_o && inhibit_o) else $error("drive not disabled after success");
	chk_start_needs_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == S_IDLE && $past(sel) == 8'h00 && sel == 8'h00) |=> state == S_IDLE) else $error("test without selector");
	chk_no_stop_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		sel != 8'h00 |=> !stop_state_o) else $error("stop state with selector set");
	chk_gains_held: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!gains_ok |=> !gain_recalc_o) else $error("gains updated with zero motor value");
	chk_rotate_dir: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == S_IDLE && start_ok && run_r) |=> ##1 reverse_o) else $error("reverse run not reversed");
	chk_volt_min: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$past(rst_b_i) |-> volt_limit_o <= $past(rated_voltage) && volt_limit_o <= $past(headroom_i))
		else $error("voltage limit above rated or headroom");
	chk_release_block: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		need_release |-> !start_ok) else $error("restart without enable removal");
	cov_short_done: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) state == S_SETTLE ##1 state == S_DONE);
	cov_trip: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) ev_trip);
	cov_gains_only: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) gain_recalc_o && sel == 8'h00);
	chk_settle_revs: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(state == S_SETTLE) |-> revs == 2'(sat_pkg::ELEC_REVS)) else $error("settle before two revolutions");
	chk_trip_no_store: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		ev_trip |=> !store_o.valid ##1 !store_o.valid) else $error("result stored after trip");
	chk_busy_rotate: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		state == S_ROTATE |=> busy_o) else $error("busy low during test");
	chk_start_disabled: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == S_IDLE && $past(enabled) && enabled && $past(sel) == 8'h00 && sel != 8'h00
		&& sel != sat_pkg::AUTOTUNE_GAINS_ONLY) |=> state == S_IDLE) else $error("test started from stop state");
	chk_gains_only: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state == S_IDLE && sel == sat_pkg::AUTOTUNE_GAINS_ONLY) |=> state == S_GAINS ##1 !store_o.valid)
		else $error("gains-only request not served");
	cov_reverse_start: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		state == S_IDLE && start_ok && run_r);
	cov_gains_store: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		store_o.valid && store_o.item == sat_pkg::ITEM_GAINS);

endmodule

// ---- dv/sat_motor_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Motor with encoder: pulses once per electrical rev while driven, coasts down after
// ----------------------------------------
module sat_motor_model #(
	parameter int STEP = 12,
	parameter logic [15:0] ANGLE = 16'h05A3
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic rotate_i,
	output logic rev_done_o,
	output logic stopped_o,
	output logic [15:0] phase_o
);
	logic [7:0] cnt;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 8'h00;
			rev_done_o <= 1'b0;
			stopped_o <= 1'b1;
		end else if (rotate_i) begin
			cnt <= (cnt >= 8'(STEP - 1)) ? 8'h00 : cnt + 8'h01;
			rev_done_o <= cnt >= 8'(STEP - 4);
			stopped_o <= 1'b0;
		end else begin
			cnt <= (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
			rev_done_o <= 1'b0;
			stopped_o <= cnt == 8'h00;
		end
	end
	// Angle only meaningful at rest; while moving it wanders every cycle
	assign phase_o = stopped_o ? ANGLE : {cnt, ~cnt};
endmodule

// ---- dv/sat_sequencer_tb.sv ----
`timescale 1ns/1ps

module sat_sequencer_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, en_pin, run_fwd, run_rev, trip, stopped, rev_done, err;
	logic usa, drive_en, inhibit, stop_state, rotate, reverse, busy, gain_recalc, irq;
	logic [1:0] rating, revs;
	logic [7:0] poles;
	logic [11:0] paddr;
	logic [15:0] phase, res, ind, headroom, vlim;
	logic [31:0] pwdata, prdata, rd;
	sat_pkg::sat_store_t store, last;
	int err_count = 0, compares = 0, store_cnt = 0, recalc_cnt = 0, gains_cnt = 0, rev_cnt = 0, s0, g0;
	logic rd_q = 1'b0;
	logic [1:0] rt [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
	logic us [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [15:0] vx [5] = '{16'h00E6, 16'h0190, 16'h01E0, 16'h023F, 16'h02B2};

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	sat_sequencer #(.SHORT_CYCLES(20)) dut (.ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .rating_i(rating), .usa_i(usa), .enable_pin_i(en_pin), .run_fwd_i(run_fwd),
		.run_rev_i(run_rev), .trip_i(trip), .motor_stopped_i(stopped), .rev_done_i(rev_done), .phase_meas_i(phase),
		.stator_res_i(res), .trans_ind_i(ind), .headroom_i(headroom), .drive_en_o(drive_en), .inhibit_o(inhibit),
		.stop_state_o(stop_state), .rotate_o(rotate), .reverse_o(reverse), .revs_target_o(revs), .busy_o(busy),
		.gain_recalc_o(gain_recalc), .poles_o(poles), .volt_limit_o(vlim), .store_o(store), .irq_o(irq));

	sat_motor_model motor (.clk_i(clk), .rst_b_i(rst_b), .rotate_i(rotate), .rev_done_o(rev_done),
		.stopped_o(stopped), .phase_o(phase));

	always @(posedge clk) begin
		if (store.valid === 1'b1) begin
			store_cnt++;
			last = store;
			if (store.item === sat_pkg::ITEM_GAINS) gains_cnt++;
		end
		if (gain_recalc === 1'b1) recalc_cnt++;
		if (rotate === 1'b1 && rev_done === 1'b1 && rd_q !== 1'b1) rev_cnt++;
		rd_q = rev_done;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until pready is sampled high; no wait count assumed
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (busy !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(busy, lvl);
	endtask

	task idle_for(input int cyc);
		int k;
		k = 0;
		repeat (cyc) begin
			@(posedge clk);
			if (busy !== 1'b0) k++;
		end
		chk(k, 0);
	endtask

	// Disable first: a test only starts from the disabled state
	task pulse_enable();
		@(posedge clk) en_pin <= 1'b0;
		repeat (6) @(posedge clk);
		en_pin <= 1'b1;
	endtask

	task do_reset(input logic [1:0] r, input logic u);
		@(posedge clk);
		rst_b <= 1'b0;
		rating <= r;
		usa <= u;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	task finish_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rating = 2'h0;
		usa = 1'b0;
		en_pin = 1'b0;
		run_fwd = 1'b0;
		run_rev = 1'b0;
		trip = 1'b0;
		res = 16'h0040;
		ind = 16'h0020;
		headroom = 16'hFFFF;
		for (int i = 0; i < 5; i++) begin
			do_reset(rt[i], us[i]);
			rchk(sat_pkg::ADDR_RATED_VOLTAGE, {16'h0, vx[i]});
		end
		chk(inhibit, 1'b1);
		rchk(sat_pkg::ADDR_POLE_COUNT, 32'h3);
		chk(poles, 8'h06);
		rchk(sat_pkg::ADDR_AUTOTUNE_SEL, 32'h0);
		apb(1'b1, sat_pkg::ADDR_POLE_COUNT, 32'h3C);
		rchk(sat_pkg::ADDR_POLE_COUNT, 32'h3C);
		chk(poles, 8'h78);
		apb(1'b1, sat_pkg::ADDR_POLE_COUNT, 32'h3D);
		rchk(sat_pkg::ADDR_POLE_COUNT, 32'h3C);
		apb(1'b1, sat_pkg::ADDR_POLE_COUNT, 32'h0);
		rchk(sat_pkg::ADDR_POLE_COUNT, 32'h0);
		chk(poles, 8'h06);
		apb(1'b1, sat_pkg::ADDR_AUTOTUNE_SEL, 32'h7);
		rchk(sat_pkg::ADDR_AUTOTUNE_SEL, 32'h0);
		apb(1'b0, 12'h024, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, sat_pkg::ADDR_RATED_VOLTAGE, 32'h100);
		headroom <= 16'h00FF;
		rchk(sat_pkg::ADDR_VOLT_LIMIT, 32'hFF);
		headroom <= 16'h0200;
		rchk(sat_pkg::ADDR_VOLT_LIMIT, 32'h100);
		chk(vlim, 16'h0100);
		// Gains-only request with the drive disabled
		s0 = recalc_cnt;
		apb(1'b1, sat_pkg::ADDR_AUTOTUNE_SEL, 32'h6);
		repeat (10) @(posedge clk);
		chk(recalc_cnt > s0, 1'b1);
		rchk(sat_pkg::ADDR_AUTOTUNE_SEL, 32'h0);
		// Enabled without run and selector zero is the stop state
		apb(1'b1, sat_pkg::ADDR_CONTROL, 32'h09);
		en_pin <= 1'b1;
		repeat (8) @(posedge clk);
		chk(stop_state, 1'b1);
		apb(1'b1, sat_pkg::ADDR_AUTOTUNE_SEL, 32'h1);
		repeat (3) @(posedge clk);
		chk(stop_state, 1'b0);
		run_fwd <= 1'b1;
		idle_for(40);
		// Short test: reverse select, second set, copy mode 3
		apb(1'b1, sat_pkg::ADDR_CONTROL, 32'h3F);
		apb(1'b1, sat_pkg::ADDR_IRQ_STATUS, 32'hF);
		s0 = store_cnt;
		pulse_enable();
		wait_busy(1'b1, 60);
		chk(reverse, 1'b1);
		chk(revs, 2'h2);
		wait_busy(1'b0, 400);
		repeat (3) @(posedge clk);
		chk(store_cnt - s0, 1);
		chk(last.item, sat_pkg::ITEM_PHASE);
		chk(last.value, 16'h05A3);
		chk(last.second_set, 1'b1);
		chk(last.card, 1'b1);
		chk(inhibit, 1'b1);
		chk(drive_en, 1'b0);
		chk(rev_cnt, 2);
		rchk(sat_pkg::ADDR_MOTOR_SET, 32'h1);
		rchk(sat_pkg::ADDR_STATUS, 32'hA);
		// Interrupt: masked, unmasked, cleared
		apb(1'b1, sat_pkg::ADDR_IRQ_MASK, 32'h0);
		rchk(sat_pkg::ADDR_IRQ_STATUS, 32'hB);
		chk(irq, 1'b0);
		apb(1'b1, sat_pkg::ADDR_IRQ_MASK, 32'h2);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		apb(1'b1, sat_pkg::ADDR_IRQ_STATUS, 32'h2);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		rchk(sat_pkg::ADDR_IRQ_STATUS, 32'h9);
		// Restart refused until enable removed, here by the enable setting
		apb(1'b1, sat_pkg::ADDR_AUTOTUNE_SEL, 32'h1);
		run_fwd <= 1'b0;
		repeat (4) @(posedge clk);
		run_fwd <= 1'b1;
		idle_for(40);
		run_fwd <= 1'b0;
		run_rev <= 1'b1;
		apb(1'b1, sat_pkg::ADDR_CONTROL, 32'h08);
		apb(1'b1, sat_pkg::ADDR_CONTROL, 32'h09);
		wait_busy(1'b1, 60);
		chk(reverse, 1'b1);
		s0 = store_cnt;
		trip <= 1'b1;
		wait_busy(1'b0, 60);
		repeat (60) @(posedge clk);
		chk(store_cnt - s0, 0);
		trip <= 1'b0;
		// Gains step: withheld while resistance is zero, stored otherwise
		do_reset(2'h3, 1'b0);
		// Copy mode 4 this time, so both card modes are exercised
		apb(1'b1, sat_pkg::ADDR_CONTROL, 32'h49);
		run_rev <= 1'b0;
		run_fwd <= 1'b1;
		for (int j = 0; j < 2; j++) begin
			res <= j ? 16'h0040 : 16'h0000;
			g0 = gains_cnt;
			apb(1'b1, sat_pkg::ADDR_AUTOTUNE_SEL, 32'h2);
			pulse_enable();
			repeat (60) @(posedge clk);
			rchk(sat_pkg::ADDR_AUTOTUNE_SEL, 32'h0);
			chk(gains_cnt - g0, j);
		end
		chk(last.item, sat_pkg::ITEM_GAINS);
		chk(last.card, 1'b1);
		chk(last.second_set, 1'b0);
		finish_test();
	end

	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule
